// *** rtl/charger_consts.svh ***
// Timing and sizing constants of the charge controller
`ifndef CHARGER_CONSTS_SVH
`define CHARGER_CONSTS_SVH
`define CLK_PERIOD_NS    25
`define CLK_KHZ          40000
`define POR_DELAY_MS     30
`define DISCH_WINDOW_MS  1000
`define TEST_WINDOW_MS   500
`define PRECHG_LIMIT_MIN 30
`define SOFT_STEP_US     1600
`define SOFT_STEPS       8
`define DEAD_TIME_NS     30
`define REFRESH_NS       80
`define DEAD_CYC    ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_CYC ((`REFRESH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SW_PERIOD_CYC    66
`define TMR_W            37
`define PER_W            7
`endif

// *** rtl/charger_pkg.sv ***
// Types shared by the charge controller
package charger_pkg;
`include "charger_consts.svh"
   typedef enum logic [2:0] {
      ST_POWERUP   = 3'b000,
      ST_DISCHARGE = 3'b001,
      ST_TEST      = 3'b010,
      ST_PRECHARGE = 3'b011,
      ST_FAST      = 3'b100,
      ST_DONE      = 3'b101,
      ST_FAULT     = 3'b110,
      ST_IDLE      = 3'b111
   } phase_type;
   typedef struct packed {
      logic sense_5mv;
      logic sense_avg_1p25mv;
      logic battery_2v;
      logic boot_low;
      logic pwm_request;
      logic input_ovp;
      logic lockout;
      logic battery_ovp;
      logic overcurrent;
      logic die_hot;
      logic die_cool;
      logic therm_cold_ok;
      logic therm_hot_start_ok;
      logic therm_hot_cutoff_ok;
      logic enable_on;
      logic enable_off;
      logic battery_low;
      logic feedback_recharge;
      logic current_term;
   } comparator_type;
   typedef struct packed {
      comparator_type    s1;
      comparator_type    s2;
      phase_type         phase;
      logic [`TMR_W-1:0] timer;
      logic [2:0]        step;
      logic              por_done;
      logic              en_on;
      logic              hot;
      logic              started;
      logic [`PER_W-1:0] per;
      logic              uc_cut;
      logic              refreshed;
      logic [2:0]        refresh_cnt;
      logic [1:0]        dead;
      logic              hs;
      logic              ls;
      logic              stat_a;
      logic              stat_b;
      logic              sink;
      logic              ref_en;
   } state_type;
endpackage

// *** rtl/charger_mode_protection_control.sv ***
// Switching-mode, protection and battery-detect control of the charger
//
// Summary of operation
// - Low-side switch driven synchronously while sense voltage exceeds 5 mV.
// - Complementary gate drive with 30 ns both-off dead time.
// - Battery below 2 V or average sense below 1.25 mV forces non-sync.
// - Discontinuous conduction: low side gives only a bootstrap refresh pulse.
// - Zero duty request keeps high side off, low side still conducts in sync mode and refreshes.
// - Sense below 5 mV turns low side off for rest of cycle.
// - Input overvoltage disables charging.
// - Undervoltage lockout holds everything but the overvoltage sink off, reference enable included.
// - Battery at or above 102% blocks high-side turn-on each cycle.
// - Battery overvoltage enables sink from positive sense node.
// - Current above 200% turns high side off, resumes automatically.
// - Die above 145 C shuts converter until below 130 C.
// - Charge start needs thermistor between cold and hot-start limits.
// - While charging thermistor must stay between cold and cutoff limits.
// - Temperature suspension turns both switches off.
// - Enable pin above 175 mV permits charging with all other conditions.
// - Enable pin below 75 mV stops charge, clears timers and faults.
// - Status: precharge or fast charge, not suspended, A on; complete B on; otherwise both off.
// - Status lines are open-drain, off means released.
// - Detection discharges 1 s, test-charges at low current on low battery.
// - Battery above recharge within 500 ms means absent, restart detection.
// - Either detection timer expiring declares battery present, starts charge.
// - Precharge not past low threshold in 30 minutes gives fault.
// - Fast charge entry ramps current target in 8 steps of 1.6 ms.
// - No charging before 30 ms after power-up.
// - Feedback above recharge with current below termination means complete.
`timescale 1ns/10ps
`default_nettype none
`include "charger_consts.svh"
module charger_mode_protection_control #(
   parameter longint unsigned POR_CYCLES    = `POR_DELAY_MS * `CLK_KHZ,
   parameter longint unsigned DISCH_CYCLES  = `DISCH_WINDOW_MS * `CLK_KHZ,
   parameter longint unsigned TEST_CYCLES   = `TEST_WINDOW_MS * `CLK_KHZ,
   parameter longint unsigned PRECHG_CYCLES =
      64'(`PRECHG_LIMIT_MIN) * 64'h0000_ea60 * 64'(`CLK_KHZ),
   parameter longint unsigned STEP_CYCLES   = `SOFT_STEP_US * `CLK_KHZ / 1000,
   parameter int              PERIOD_CYCLES = `SW_PERIOD_CYC
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               ce,
   input  wire logic               sense_above_5mv,
   input  wire logic               sense_avg_above_1p25mv,
   input  wire logic               battery_above_2v,
   input  wire logic               boot_below_4v2,
   input  wire logic               pwm_request,
   input  wire logic               input_overvoltage,
   input  wire logic               undervoltage_lockout,
   input  wire logic               battery_over_102pct,
   input  wire logic               current_over_200pct,
   input  wire logic               die_overtemp,
   input  wire logic               die_below_130c,
   input  wire logic               thermistor_below_cold_limit,
   input  wire logic               thermistor_above_hot_start_limit,
   input  wire logic               thermistor_above_hot_cutoff_limit,
   input  wire logic               enable_setpoint_above_175mv,
   input  wire logic               enable_setpoint_below_75mv,
   input  wire logic               battery_below_low_battery_threshold,
   input  wire logic               feedback_above_recharge_threshold,
   input  wire logic               current_below_termination,
   output logic                    high_side_gate,
   output logic                    low_side_gate,
   output logic                    sense_pos_node_sink,
   output logic                    sense_neg_node_discharge,
   output logic                    test_charge,
   output logic                    reference_enable,
   output logic [2:0]              soft_start_step,
   output charger_pkg::phase_type  charge_phase,
   output logic                    status_line_a_out,
   output logic                    status_line_a_oe,
   output logic                    status_line_b_out,
   output logic                    status_line_b_oe
);
   import charger_pkg::*;

   state_type      r;
   state_type      next_r;
   comparator_type raw;
   comparator_type c;
   logic           cyc_start;
   logic           ok;
   logic           run;
   logic           hs_want;
   logic           ls_want;
   logic           sync_mode;

   // ======================================================
   // Helpers
   function automatic logic expired(input logic [`TMR_W-1:0] t,
                                    input longint unsigned lim);
      return t >= `TMR_W'(lim - 64'd1);
   endfunction

   function automatic logic charging(input phase_type p);
      return p == ST_TEST || p == ST_PRECHARGE || p == ST_FAST;
   endfunction

   // ======================================================
   // Comparator inputs, all asynchronous to clk
   assign raw = '{sense_5mv: sense_above_5mv,
                  sense_avg_1p25mv: sense_avg_above_1p25mv,
                  battery_2v: battery_above_2v,
                  boot_low: boot_below_4v2,
                  pwm_request: pwm_request,
                  input_ovp: input_overvoltage,
                  lockout: undervoltage_lockout,
                  battery_ovp: battery_over_102pct,
                  overcurrent: current_over_200pct,
                  die_hot: die_overtemp,
                  die_cool: die_below_130c,
                  therm_cold_ok: thermistor_below_cold_limit,
                  therm_hot_start_ok: thermistor_above_hot_start_limit,
                  therm_hot_cutoff_ok: thermistor_above_hot_cutoff_limit,
                  enable_on: enable_setpoint_above_175mv,
                  enable_off: enable_setpoint_below_75mv,
                  battery_low: battery_below_low_battery_threshold,
                  feedback_recharge: feedback_above_recharge_threshold,
                  current_term: current_below_termination};
   assign c = r.s2; // Only the second stage is ever read

   // ======================================================
   // Charge permission and converter gating terms
   always_comb begin
      cyc_start = (r.per == '0);
      ok = r.en_on && !c.input_ovp && !r.hot && r.por_done
           && c.therm_cold_ok
           && (r.started ? c.therm_hot_cutoff_ok : c.therm_hot_start_ok);
      run = ok && charging(r.phase);
      sync_mode = c.sense_5mv && c.sense_avg_1p25mv && c.battery_2v;
      hs_want = run && c.pwm_request && !c.battery_ovp && !c.overcurrent;
      ls_want = run && !hs_want
                && ((sync_mode && !r.uc_cut) || r.refresh_cnt != 3'h0);
   end

   // ======================================================
   // Next-state logic
   always_comb begin
      next_r = r;
      next_r.s1 = raw;
      next_r.s2 = r.s1;
      next_r.ref_en = !c.lockout;
      next_r.sink = c.battery_ovp;
      // Die temperature hysteresis
      if (c.die_hot) begin
         next_r.hot = 1'b1;
      end else if (c.die_cool) begin
         next_r.hot = 1'b0;
      end
      if (c.enable_on) begin
         next_r.en_on = 1'b1;
      end else if (c.enable_off) begin
         next_r.en_on = 1'b0;
      end
      next_r.started = run || (r.started && charging(r.phase));
      // Switching period and per-cycle flags
      next_r.per = (r.per == `PER_W'(PERIOD_CYCLES - 1)) ? '0 : r.per + `PER_W'(1);
      next_r.uc_cut = !c.sense_5mv || (r.uc_cut && !cyc_start);  // set wins
      if (cyc_start) begin
         next_r.refreshed = 1'b0;
      end
      if (r.refresh_cnt != 3'h0) begin
         next_r.refresh_cnt = r.refresh_cnt - 3'h1;
      end else if (run && c.boot_low && !hs_want && !r.refreshed) begin
         next_r.refresh_cnt = 3'(`REFRESH_CYC);
         next_r.refreshed = 1'b1;
      end
      // Break-before-make: any change passes through both-off
      if ({r.hs, r.ls} != 2'b00 && {hs_want, ls_want} != {r.hs, r.ls}) begin
         next_r.hs = 1'b0;
         next_r.ls = 1'b0;
         next_r.dead = 2'(`DEAD_CYC);
      end else if ({r.hs, r.ls} == 2'b00 && r.dead != 2'h0) begin
         next_r.dead = r.dead - 2'h1;
      end else begin
         next_r.hs = hs_want;
         next_r.ls = ls_want;
      end
      // Timer advances while not suspended, and always in power-up and discharge, so suspension does not eat it
      if (ok || !r.por_done || r.phase == ST_DISCHARGE) begin
         next_r.timer = r.timer + `TMR_W'(1);
      end
      // Phase sequencing
      case (r.phase)
         ST_POWERUP: begin
            if (expired(r.timer, POR_CYCLES)) begin
               next_r.por_done = 1'b1;
               next_r.phase = ST_IDLE;
               next_r.timer = '0;
            end
         end
         ST_IDLE: begin
            if (r.en_on) begin
               next_r.phase = ST_DISCHARGE;
               next_r.timer = '0;
            end
         end
         ST_DISCHARGE: begin
            if (c.battery_low) begin
               next_r.phase = ST_TEST;
               next_r.timer = '0;
            end else if (expired(r.timer, DISCH_CYCLES)) begin
               next_r.phase = ST_FAST;
               next_r.timer = '0;
               next_r.step = 3'h0;
            end
         end
         ST_TEST: begin
            if (c.feedback_recharge) begin
               next_r.phase = ST_DISCHARGE;
               next_r.timer = '0;
            end else if (expired(r.timer, TEST_CYCLES)) begin
               next_r.phase = c.battery_low ? ST_PRECHARGE : ST_FAST;
               next_r.timer = '0;
               next_r.step = 3'h0;
            end
         end
         ST_PRECHARGE: begin
            if (!c.battery_low) begin
               next_r.phase = ST_FAST;
               next_r.timer = '0;
               next_r.step = 3'h0;
            end else if (expired(r.timer, PRECHG_CYCLES)) begin
               next_r.phase = ST_FAULT;
            end
         end
         ST_FAST: begin
            if (c.feedback_recharge && c.current_term) begin
               next_r.phase = ST_DONE;
            end else if (r.step != 3'(`SOFT_STEPS - 1)
                         && expired(r.timer, STEP_CYCLES)) begin
               next_r.step = r.step + 3'h1;
               next_r.timer = '0;
            end
         end
         ST_DONE: begin
            if (!c.feedback_recharge) begin
               next_r.phase = ST_FAST;                           // New cycle on recharge
               next_r.timer = '0;
               next_r.step = 3'h0;
            end
         end
         ST_FAULT: begin
            next_r.timer = r.timer;                              // Held until enable drops
         end
         default: begin
            next_r.phase = ST_IDLE;
         end
      endcase
      // Enable withdrawn: drop charge, clear timers and latched faults
      if (r.por_done && !r.en_on) begin
         next_r.phase = ST_IDLE;
         next_r.timer = '0;
         next_r.step = 3'h0;
      end
      // Open-drain status, transistor on means pulled low
      next_r.stat_a = ok && (r.phase == ST_PRECHARGE || r.phase == ST_FAST);
      next_r.stat_b = r.phase == ST_DONE;
      // Lockout overrides all but the sink: restart from power-up
      if (c.lockout) begin
         next_r.phase = ST_POWERUP;
         next_r.por_done = 1'b0;
         next_r.timer = '0;
         next_r.step = 3'h0;
         next_r.hs = 1'b0;
         next_r.ls = 1'b0;
         next_r.stat_a = 1'b0;
         next_r.stat_b = 1'b0;
      end
   end

   // ======================================================
   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '{phase: ST_POWERUP, default: '0};
      end else if (ce) begin
         r <= next_r;
      end
   end

   // ======================================================
   // Outputs
   assign high_side_gate = r.hs;
   assign low_side_gate = r.ls;
   assign sense_pos_node_sink = r.sink;
   assign sense_neg_node_discharge = r.phase == ST_DISCHARGE;
   assign test_charge = r.phase == ST_TEST;
   assign reference_enable = r.ref_en;
   assign soft_start_step = r.step;
   assign charge_phase = r.phase;
   assign status_line_a_out = 1'b0;
   assign status_line_b_out = 1'b0;
   assign status_line_a_oe = r.stat_a;
   assign status_line_b_oe = r.stat_b;

   // ======================================================
   // Checks
   AST_NO_SHOOT: assert property (@(posedge clk) disable iff (rst)
      !(r.hs && r.ls)) else $error("both switches on");
   AST_DEAD: assert property (@(posedge clk) disable iff (rst || !ce)
      $fell(r.ls) |-> !r.hs ##1 !r.hs) else $error("dead time short");
   AST_OVP_BLOCK: assert property (@(posedge clk) disable iff (rst || !ce)
      c.battery_ovp |=> !r.hs) else $error("high side on in overvoltage");
   AST_OC_OFF: assert property (@(posedge clk) disable iff (rst || !ce)
      c.overcurrent |=> !r.hs) else $error("high side on in overcurrent");
   AST_SINK: assert property (@(posedge clk) disable iff (rst || !ce)
      c.battery_ovp |=> r.sink) else $error("sink not enabled");
   AST_LOCKOUT: assert property (@(posedge clk) disable iff (rst || !ce)
      c.lockout |=> !r.ref_en && !r.hs && !r.ls && r.phase == ST_POWERUP)
      else $error("lockout not honoured");
   AST_HOT: assert property (@(posedge clk) disable iff (rst || !ce)
      r.hot |=> !r.hs && !r.ls) else $error("switching while hot");
   AST_STATUS: assert property (@(posedge clk) disable iff (rst)
      !(r.stat_a && r.stat_b)) else $error("both status lines on");
   AST_EN_OFF: assert property (@(posedge clk) disable iff (rst || !ce)
      r.por_done && !r.en_on && !c.lockout |=> r.phase == ST_IDLE && r.timer == '0)
      else $error("disable did not clear");
   AST_UNDERCUR: assert property (@(posedge clk) disable iff (rst || !ce)
      r.uc_cut && !cyc_start && r.refresh_cnt == 3'h0 |=> !r.ls)
      else $error("low side on after undercurrent");
endmodule // charger_mode_protection_control
`default_nettype wire

// *** verification/battery_status_model.sv ***
// Behavioural battery, cell-presence and status-pin model beside the charger
`timescale 1ns/10ps
`default_nettype none
module battery_status_model (
   input  wire logic       clk,
   input  wire logic [1:0] mode,
   input  wire logic       sense_neg_node_discharge,
   input  wire logic       test_charge,
   input  wire logic       status_line_a_out,
   input  wire logic       status_line_a_oe,
   input  wire logic       status_line_b_out,
   input  wire logic       status_line_b_oe,
   output logic            battery_below_low_battery_threshold,
   output logic            feedback_above_recharge_threshold,
   output wire logic       status_line_a,
   output wire logic       status_line_b
);
   // Modes: 0 charged cell, 1 no cell, 2 deeply drained cell, 3 full cell
   logic [3:0] drain;

   // =======================================================
   // Output node
   // An empty node needs a few cycles of sink current to fall
   always_ff @(posedge clk) begin
      if (!sense_neg_node_discharge) drain <= 4'h0;
      else if (drain != 4'hf) drain <= drain + 4'h1;
   end

   // Threshold levels as the comparators would report them
   always_comb begin
      battery_below_low_battery_threshold = (mode == 2'd2) || (mode == 2'd1 && drain >= 4'h5);
      feedback_above_recharge_threshold = (mode == 2'd3) || (mode == 2'd1 && test_charge);
   end

   // =======================================================
   // Status pins
   // Pull-ups: a released transistor reads high, never the last level
   assign status_line_a = status_line_a_oe ? status_line_a_out : 1'b1;
   assign status_line_b = status_line_b_oe ? status_line_b_out : 1'b1;
endmodule // battery_status_model
`default_nettype wire

// *** verification/charger_mode_protection_control_bench.sv ***
// Self-checking bench of the charger mode and protection control
`timescale 1ns/10ps
`default_nettype none
module charger_mode_protection_control_bench;
   import charger_pkg::*;
   localparam int POR = 20;
   localparam int DISCH = 50;
   localparam int TEST = 30;
   localparam int PRE = 100;
   localparam int STEP = 10;
   localparam int PER = 66;
   logic clk, rst, ce, sense_above_5mv, sense_avg_above_1p25mv, battery_above_2v;
   logic boot_below_4v2, pwm_request, input_overvoltage, undervoltage_lockout;
   logic battery_over_102pct, current_over_200pct, die_overtemp, die_below_130c;
   logic thermistor_below_cold_limit, thermistor_above_hot_start_limit;
   logic thermistor_above_hot_cutoff_limit, enable_setpoint_above_175mv;
   logic enable_setpoint_below_75mv, current_below_termination;
   logic battery_below_low_battery_threshold, feedback_above_recharge_threshold;
   logic high_side_gate, low_side_gate, sense_pos_node_sink, sense_neg_node_discharge;
   logic test_charge, reference_enable, status_line_a_out, status_line_a_oe;
   logic status_line_b_out, status_line_b_oe;
   logic [2:0] soft_start_step;
   phase_type  charge_phase;
   wire logic  status_line_a, status_line_b;
   logic [1:0] mode, hs_p, ls_p;
   int         mismatches, tests_run;

   // Short counts keep the detection and precharge timers quick
   charger_mode_protection_control #(.POR_CYCLES(POR), .DISCH_CYCLES(DISCH),
      .TEST_CYCLES(TEST), .PRECHG_CYCLES(PRE), .STEP_CYCLES(STEP)) dut (.*);
   battery_status_model model (.*);

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Shoot-through and dead time watch on every rising edge
   always @(posedge clk) begin
      if (!rst && ((high_side_gate && (low_side_gate || ls_p != 2'b00))
                   || (low_side_gate && hs_p != 2'b00))) begin
         mismatches++;
         $display("[FAIL] dead_time expected 1 seen 0");
      end
      hs_p <= {hs_p[0], high_side_gate};
      ls_p <= {ls_p[0], low_side_gate};
   end

   // =======================================================
   // Shared tasks
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic test_done;
      $display("Checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Bounded wait; a miss ends the run
   task automatic wait_phase(input phase_type p, input int lim);
      for (int i = 0; i < lim && charge_phase !== p; i++) cyc(1);
      check("phase", 8'(p), 8'(charge_phase));
      if (charge_phase !== p) test_done();
   endtask

   task automatic set_fault(input int k, input logic v);
      case (k)
         0: battery_over_102pct = v;
         1: current_over_200pct = v;
         2: input_overvoltage = v;
         3: thermistor_below_cold_limit = !v;
         default: thermistor_above_hot_cutoff_limit = !v;
      endcase
   endtask

   // =======================================================
   // Scenarios
   task automatic t_powerup;
      cyc(POR / 2);
      check("phase", 8'(ST_POWERUP), 8'(charge_phase));
      check("gates", 8'h00, {6'h0, high_side_gate, low_side_gate});
      check("ref_en", 8'h01, 8'(reference_enable));
      wait_phase(ST_DISCHARGE, POR + 10);
      check("disch", 8'h01, 8'(sense_neg_node_discharge));
   endtask

   // Charged cell: discharge timer runs out, then soft start
   task automatic t_present;
      wait_phase(ST_FAST, DISCH + 10);
      check("step", 8'h00, 8'(soft_start_step));
      cyc(STEP + 2);
      check("step", 8'h01, 8'(soft_start_step));
      check("stat", 8'h01, {6'h0, status_line_a, status_line_b});
      cyc(7 * STEP);
      check("step", 8'h07, 8'(soft_start_step));
   endtask

   task automatic t_gates;
      int n;
      pwm_request = 1'b1;
      cyc(8);
      check("hs", 8'h01, 8'(high_side_gate));
      pwm_request = 1'b0;
      cyc(8);
      check("gates", 8'h01, {6'h0, high_side_gate, low_side_gate});
      sense_above_5mv = 1'b0;
      cyc(5);
      check("ls", 8'h00, 8'(low_side_gate));
      sense_above_5mv = 1'b1;
      battery_above_2v = 1'b0;
      cyc(PER + 8);
      check("ls", 8'h00, 8'(low_side_gate));
      battery_above_2v = 1'b1;
      sense_avg_above_1p25mv = 1'b0;
      cyc(PER + 8);
      check("ls", 8'h00, 8'(low_side_gate));
      sense_avg_above_1p25mv = 1'b1;
      // Light load with a sagging bootstrap: one short refresh pulse
      sense_above_5mv = 1'b0;
      boot_below_4v2 = 1'b1;
      for (int i = 0; i < 2 * PER && low_side_gate !== 1'b1; i++) cyc(1);
      check("ls", 8'h01, {7'h0, low_side_gate});
      if (low_side_gate !== 1'b1) test_done();
      for (n = 0; n < 20 && low_side_gate === 1'b1; n++) cyc(1);
      check("refresh", 8'h04, 8'(n));
      check("hs", 8'h00, 8'(high_side_gate));
      boot_below_4v2 = 1'b0;
      sense_above_5mv = 1'b1;
   endtask

   // Each protection input in turn, with the high side wanted
   task automatic t_protect;
      pwm_request = 1'b1;
      for (int k = 0; k < 5; k++) begin
         cyc(10);
         check("hs", 8'h01, 8'(high_side_gate));
         set_fault(k, 1'b1);
         cyc(2);
         check("hs", 8'h01, 8'(high_side_gate));
         cyc(2);
         check("hs", 8'h00, 8'(high_side_gate));
         check("sink", 8'(k == 0), 8'(sense_pos_node_sink));
         if (k >= 2) check("ls", 8'h00, 8'(low_side_gate));
         set_fault(k, 1'b0);
      end
      cyc(10);
      check("hs", 8'h01, 8'(high_side_gate));
      die_overtemp = 1'b1;
      die_below_130c = 1'b0;
      cyc(4);
      check("hs", 8'h00, 8'(high_side_gate));
      die_overtemp = 1'b0;
      cyc(10);
      check("hs", 8'h00, 8'(high_side_gate));
      die_below_130c = 1'b1;
      cyc(10);
      check("hs", 8'h01, 8'(high_side_gate));
      pwm_request = 1'b0;
   endtask

   task automatic t_done;
      mode = 2'd3;
      current_below_termination = 1'b1;
      wait_phase(ST_DONE, 10);
      cyc(2);
      check("stat", 8'h02, {6'h0, status_line_a, status_line_b});
      mode = 2'd0;
      current_below_termination = 1'b0;
      wait_phase(ST_FAST, 10);
      check("step", 8'h00, 8'(soft_start_step));
   endtask

   // Enable pin off, then on again
   task automatic t_enable;
      enable_setpoint_above_175mv = 1'b0;
      enable_setpoint_below_75mv = 1'b1;
      wait_phase(ST_IDLE, 10);
      cyc(20);
      check("phase", 8'(ST_IDLE), 8'(charge_phase));
      check("step", 8'h00, 8'(soft_start_step));
      check("stat", 8'h03, {6'h0, status_line_a, status_line_b});
      check("gates", 8'h00, {6'h0, high_side_gate, low_side_gate});
      enable_setpoint_above_175mv = 1'b1;
      enable_setpoint_below_75mv = 1'b0;
      wait_phase(ST_DISCHARGE, 10);
   endtask

   task automatic t_absent;
      mode = 2'd1;
      wait_phase(ST_TEST, 20);
      check("tchg", 8'h01, {7'h0, test_charge});
      check("disch", 8'h00, {7'h0, sense_neg_node_discharge});
      wait_phase(ST_DISCHARGE, 10);
   endtask

   // Drained cell: test timeout, precharge timeout, fault, then clear
   task automatic t_deep;
      // Too warm to start: test charge holds with both switches off
      thermistor_above_hot_start_limit = 1'b0;
      mode = 2'h2;
      wait_phase(ST_TEST, 10);
      cyc(TEST + 10);
      check("phase", 8'(ST_TEST), 8'(charge_phase));
      check("gates", 8'h00, {6'h0, high_side_gate, low_side_gate});
      thermistor_above_hot_start_limit = 1'b1;
      wait_phase(ST_PRECHARGE, TEST + 10);
      cyc(2);
      check("stat", 8'h01, {6'h0, status_line_a, status_line_b});
      wait_phase(ST_FAULT, PRE + 10);
      cyc(2);
      check("stat", 8'h03, {6'h0, status_line_a, status_line_b});
      mode = 2'd0;
      t_enable();
   endtask

   task automatic t_lockout;
      undervoltage_lockout = 1'b1;
      cyc(4);
      check("ref_en", 8'h00, 8'(reference_enable));
      check("phase", 8'(ST_POWERUP), 8'(charge_phase));
      check("outs", 8'h00, {3'h0, high_side_gate, low_side_gate, sense_pos_node_sink,
                            sense_neg_node_discharge, test_charge});
      undervoltage_lockout = 1'b0;
      wait_phase(ST_DISCHARGE, POR + 10);
   endtask

   // =======================================================
   // Main sequence
   initial begin
      mismatches = 0;
      tests_run = 0;
      {sense_above_5mv, sense_avg_above_1p25mv, battery_above_2v, die_below_130c,
       thermistor_below_cold_limit, thermistor_above_hot_start_limit,
       thermistor_above_hot_cutoff_limit, enable_setpoint_above_175mv, ce, rst} = '1;
      {boot_below_4v2, pwm_request, input_overvoltage, undervoltage_lockout,
       battery_over_102pct, current_over_200pct, die_overtemp,
       enable_setpoint_below_75mv, current_below_termination, mode} = '0;
      cyc(10);
      rst = 1'b0;
      t_powerup();
      t_present();
      t_gates();
      t_protect();
      t_done();
      t_enable();
      t_absent();
      t_deep();
      t_lockout();
      test_done();
   end
endmodule // charger_mode_protection_control_bench
`default_nettype wire
